// ===== hw/tcc_pkg.sv
// Constants for the timer capture/compare block: register map, field
// positions, reset values and the edge and pin-action encodings.
// Holds definitions only; every file that uses them names them as tcc_pkg::NAME.
package tcc_pkg;

  localparam int unsigned CNT_W = 16;

  //////////////////////////////////////////////////////////////////////////////
  // Byte addresses of the word registers
  localparam logic [7:0] OFS_EDGE    = 8'h00;
  localparam logic [7:0] OFS_ACTION  = 8'h04;
  localparam logic [7:0] OFS_MASK    = 8'h08;
  localparam logic [7:0] OFS_FLAG    = 8'h0C;
  localparam logic [7:0] OFS_CTRL    = 8'h10;
  localparam logic [7:0] OFS_PINMASK = 8'h14;
  localparam logic [7:0] OFS_PINDATA = 8'h18;
  localparam logic [7:0] OFS_CAP1    = 8'h20;
  localparam logic [7:0] OFS_CAP2    = 8'h24;
  localparam logic [7:0] OFS_CAP3    = 8'h28;
  localparam logic [7:0] OFS_SHARED  = 8'h2C;
  localparam logic [7:0] OFS_CMP1    = 8'h30;
  localparam logic [7:0] OFS_CMP2    = 8'h34;
  localparam logic [7:0] OFS_CMP3    = 8'h38;
  localparam logic [7:0] OFS_CMP4    = 8'h3C;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] CMP_RESET  = 16'hFFFF;
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [4:0]  PIN_RESET  = 5'h00;

  // Field positions
  localparam int unsigned PIN_LSB   = 3;
  localparam int unsigned CTRL_FSEL = 0;
  localparam int unsigned CTRL_DIR  = 1;
  localparam int unsigned CTRL_PA3  = 2;
  localparam int unsigned LANE_HI   = 1;

  // Encodings
  localparam logic [1:0] EDGE_OFF   = 2'h0;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_FALL  = 2'h2;
  localparam logic [1:0] EDGE_ANY   = 2'h3;
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_LOW    = 2'h2;
  localparam logic [1:0] ACT_HIGH   = 2'h3;
  localparam logic [2:0] SIZE_BYTE  = 3'h0;
  localparam logic [2:0] SIZE_HALF  = 3'h1;

endpackage : tcc_pkg

// ===== hw/tcc_edge.sv
// Edge detector of one capture channel with a two-bit edge selection.
// Assumes the pin is synchronous to hclk.
`timescale 1ns/1ps
module tcc_edge (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  output logic            hit
);

  typedef struct packed {
    logic prev;
    logic armed;
  } tcc_edge_s;

  tcc_edge_s s_q;
  tcc_edge_s s_d;
  logic      rise;
  logic      fall;

  // First sample after reset only arms, so a high pin is not a rising edge
  always_comb begin
    s_d       = s_q;
    s_d.prev  = pin;
    s_d.armed = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise = s_q.armed & pin & ~s_q.prev;
  assign fall = s_q.armed & ~pin & s_q.prev;

  always_comb begin
    case (edge_sel)
      tcc_pkg::EDGE_OFF:  hit = 1'b0;
      tcc_pkg::EDGE_RISE: hit = rise;
      tcc_pkg::EDGE_FALL: hit = fall;
      tcc_pkg::EDGE_ANY:  hit = rise | fall;
    endcase
  end

  AST_EDGE_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
    ($fell(pin) && s_q.armed && edge_sel == tcc_pkg::EDGE_FALL) |-> hit)
    else $error("falling edge not detected");

  AST_EDGE_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (edge_sel == tcc_pkg::EDGE_OFF || (edge_sel == tcc_pkg::EDGE_RISE && !pin)) |-> !hit)
    else $error("edge reported while not selected");

endmodule : tcc_edge

// ===== hw/tcc_cmp.sv
// One compare channel: 16-bit register with byte writes and its comparator.
// Assumes count_step marks the first cycle of each new count value.
`timescale 1ns/1ps
module tcc_cmp (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic [tcc_pkg::CNT_W-1:0] count,
  input  wire logic                      count_step,
  input  wire logic                      wr_lo,
  input  wire logic                      wr_hi,
  input  wire logic [tcc_pkg::CNT_W-1:0] wdata,
  input  wire logic                      hold,
  input  wire logic                      load,
  input  wire logic [tcc_pkg::CNT_W-1:0] load_val,
  output logic      [tcc_pkg::CNT_W-1:0] value,
  output logic                           match
);

  typedef struct packed {
    logic [tcc_pkg::CNT_W-1:0] val;
    logic                      inhibit;
  } tcc_cmp_s;

  tcc_cmp_s s_q;
  tcc_cmp_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.inhibit = wr_hi & ~hold;
    if (load) begin
      s_d.val = load_val;
    end else if (!hold) begin
      if (wr_lo) begin
        s_d.val[7:0] = wdata[7:0];
      end
      if (wr_hi) begin
        s_d.val[15:8] = wdata[15:8];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{val: tcc_pkg::CMP_RESET, inhibit: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign value = s_q.val;
  assign match = count_step & ~s_q.inhibit & (count == s_q.val);

  AST_CMP_INHIBIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_hi && !hold) |=> !match)
    else $error("compare fired right after high-byte write");

  AST_CMP_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (hold && !load) |=> (value == $past(value)))
    else $error("held register changed by a write");

endmodule : tcc_cmp

// ===== hw/tcc_top.sv
// Timer capture/compare channels behind an AHB-Lite register slave.
// Assumes an outside counter gives the count and a one-cycle count_step.
`timescale 1ns/1ps
module tcc_top #(
  parameter int unsigned NUM_CAP = 3,
  parameter int unsigned NUM_CMP = 5
) (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire logic [tcc_pkg::CNT_W-1:0] free_running_count,
  input  wire logic                      count_step,
  input  wire logic [NUM_CAP-1:0]        capture_pin,
  input  wire logic                      port_a_bit_three_in,
  output logic                           port_a_bit_three_oe,
  output logic [4:0]                     port_a_out,
  output logic                           timer_irq
);

  if (NUM_CAP != 3 || NUM_CMP != 5) begin : g_check
    $error("tcc_top serves three capture and five compare channels");
  end

  localparam int unsigned NCH = NUM_CAP + 1;
  localparam logic [7:0] CAP_OFS [NCH] = '{tcc_pkg::OFS_CAP1, tcc_pkg::OFS_CAP2,
                                           tcc_pkg::OFS_CAP3, tcc_pkg::OFS_SHARED};
  localparam logic [7:0] CMP_OFS [NUM_CMP] = '{tcc_pkg::OFS_CMP1, tcc_pkg::OFS_CMP2,
                                               tcc_pkg::OFS_CMP3, tcc_pkg::OFS_CMP4,
                                               tcc_pkg::OFS_SHARED};

  typedef struct packed {
    logic [7:0]  edge_ctl;
    logic [7:0]  action;
    logic [7:0]  irq_mask;
    logic [7:0]  flag;
    logic        fsel;
    logic        dir;
    logic [4:0]  pin_mask;
    logic [4:0]  pin_data;
    logic [4:0]  pa;
    logic [3:0]  blk;
    logic [3:0]  pend;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [3:0]  wr_lanes;
    logic [31:0] rdata;
  } tcc_ctl_s;

  // Capture data is kept apart: it has no reset at all
  typedef struct packed {
    logic [NUM_CAP-1:0][tcc_pkg::CNT_W-1:0] cap;
    logic [NCH-1:0][tcc_pkg::CNT_W-1:0]     held;
  } tcc_cap_s;

  tcc_ctl_s c_q;
  tcc_ctl_s c_d;
  tcc_cap_s k_q;
  tcc_cap_s k_d;

  //////////////////////////////////////////////////////////////////////////////
  // Byte lanes of an access; used for the address and data phases
  function automatic logic [3:0] lanes_f(input logic [2:0] size, input logic [1:0] a);
    if (size == tcc_pkg::SIZE_BYTE) begin
      lanes_f = 4'(4'h1 << a);
    end else if (size == tcc_pkg::SIZE_HALF) begin
      lanes_f = a[1] ? 4'hC : 4'h3;
    end else begin
      lanes_f = 4'hF;
    end
  endfunction : lanes_f

  logic                      acc;
  logic                      acc_rd;
  logic                      acc_wr;
  logic [3:0]                rd_lanes;
  logic [31:0]               rd_word;
  logic [NCH-1:0]            hit;
  logic [NCH-1:0]            evt;
  logic [NCH-1:0]            go;
  logic [tcc_pkg::CNT_W-1:0] wval [NCH];
  logic [NUM_CMP-1:0]        match;
  logic [NUM_CMP-1:0]        act;
  logic [tcc_pkg::CNT_W-1:0] cmp_val [NUM_CMP];
  logic [7:0]                flag_set;
  logic [7:0]                flag_clr;
  logic [NCH-1:0]            cap_src;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: a read behind a write waits one cycle so it sees new data
  assign acc       = hsel & htrans[1] & hready;
  assign acc_wr    = acc & hwrite;
  assign acc_rd    = acc & ~hwrite & ~c_q.wr_pend;
  assign hreadyout = ~(c_q.wr_pend & hsel & htrans[1] & ~hwrite);
  assign hresp     = 1'b0;
  assign hrdata    = c_q.rdata;
  assign rd_lanes  = lanes_f(hsize, haddr[1:0]);

  always_comb begin
    rd_word = '0;
    if (haddr[31:8] == '0) begin
      unique case ({haddr[7:2], 2'h0})
        tcc_pkg::OFS_EDGE:    rd_word = 32'(c_q.edge_ctl);
        tcc_pkg::OFS_ACTION:  rd_word = 32'(c_q.action);
        tcc_pkg::OFS_MASK:    rd_word = 32'(c_q.irq_mask);
        tcc_pkg::OFS_FLAG:    rd_word = 32'(c_q.flag);
        tcc_pkg::OFS_CTRL:    rd_word = 32'({c_q.pa[0], c_q.dir, c_q.fsel});
        tcc_pkg::OFS_PINMASK: rd_word = 32'({c_q.pin_mask, 3'h0});
        tcc_pkg::OFS_PINDATA: rd_word = 32'({c_q.pin_data, 3'h0});
        tcc_pkg::OFS_CAP1:    rd_word = 32'(k_q.cap[0]);
        tcc_pkg::OFS_CAP2:    rd_word = 32'(k_q.cap[1]);
        tcc_pkg::OFS_CAP3:    rd_word = 32'(k_q.cap[2]);
        tcc_pkg::OFS_SHARED:  rd_word = 32'(cmp_val[4]);
        tcc_pkg::OFS_CMP1:    rd_word = 32'(cmp_val[0]);
        tcc_pkg::OFS_CMP2:    rd_word = 32'(cmp_val[1]);
        tcc_pkg::OFS_CMP3:    rd_word = 32'(cmp_val[2]);
        tcc_pkg::OFS_CMP4:    rd_word = 32'(cmp_val[3]);
        default:              rd_word = '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Capture channels
  // a driven bit three is seen from its own output
  assign cap_src = {port_a_bit_three_oe ? c_q.pa[0] : port_a_bit_three_in, capture_pin};

  for (genvar i = 0; i < NCH; i++) begin : g_cap
    tcc_edge u_edge (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .pin      (cap_src[i]),
      .edge_sel (c_q.edge_ctl[7 - 2 * ((i + 1) % NCH) -: 2]),
      .hit      (hit[i])
    );
    // channel four captures only when selected
    if (i == NUM_CAP) begin : g_sh
      assign evt[i] = hit[i] & c_q.fsel;
    end else begin : g_pl
      assign evt[i] = hit[i];
    end
    // a held capture goes in once unblocked
    assign go[i]   = (evt[i] | c_q.pend[i]) & ~c_q.blk[i];
    assign wval[i] = evt[i] ? free_running_count : k_q.held[i];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compare channels; index four is the shared register
  for (genvar j = 0; j < NUM_CMP; j++) begin : g_cmp
    logic sh;
    assign sh = (j == NUM_CMP - 1);
    tcc_cmp u_cmp (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .count      (free_running_count),
      .count_step (count_step),
      .wr_lo      (c_q.wr_pend & (c_q.wr_addr == CMP_OFS[j]) & c_q.wr_lanes[0]),
      .wr_hi      (c_q.wr_pend & (c_q.wr_addr == CMP_OFS[j]) & c_q.wr_lanes[tcc_pkg::LANE_HI]),
      .wdata      (hwdata[tcc_pkg::CNT_W-1:0]),
      .hold       (sh & c_q.fsel),
      .load       (sh & go[NCH-1]),
      .load_val   (wval[NCH-1]),
      .value      (cmp_val[j]),
      .match      (match[j])
    );
  end

  // fifth compare only when not capturing
  assign act = {match[4] & ~c_q.fsel, match[3:0]};

  // flag sources, bit for bit with the mask
  assign flag_set = {act[0], act[1], act[2], act[3], c_q.fsel ? evt[3] : act[4],
                     evt[0], evt[1], evt[2]};
  assign flag_clr = (c_q.wr_pend && c_q.wr_addr == tcc_pkg::OFS_FLAG && c_q.wr_lanes[0])
                    ? hwdata[7:0] : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    c_d         = c_q;
    k_d         = k_q;
    c_d.blk     = '0;
    c_d.wr_pend = 1'b0;
    if (acc_wr) begin
      // Word address only, so a byte write to an upper lane still decodes
      c_d.wr_pend  = (haddr[31:8] == '0);
      c_d.wr_addr  = {haddr[7:2], 2'h0};
      c_d.wr_lanes = lanes_f(hsize, haddr[1:0]);
    end
    if (acc_rd) begin
      c_d.rdata = rd_word;
      for (int i = 0; i < NCH; i++) begin
        if (haddr[31:8] == '0 && {haddr[7:2], 2'h0} == CAP_OFS[i] && rd_lanes[tcc_pkg::LANE_HI]) begin
          c_d.blk[i] = 1'b1;
        end
      end
    end
    if (c_q.wr_pend && c_q.wr_lanes[0]) begin
      unique case (c_q.wr_addr)
        tcc_pkg::OFS_EDGE:    c_d.edge_ctl = hwdata[7:0];
        tcc_pkg::OFS_ACTION:  c_d.action   = hwdata[7:0];
        tcc_pkg::OFS_MASK:    c_d.irq_mask = hwdata[7:0];
        tcc_pkg::OFS_PINMASK: c_d.pin_mask = hwdata[7:tcc_pkg::PIN_LSB];
        tcc_pkg::OFS_PINDATA: c_d.pin_data = hwdata[7:tcc_pkg::PIN_LSB];
        tcc_pkg::OFS_CTRL: begin
          c_d.fsel  = hwdata[tcc_pkg::CTRL_FSEL];
          c_d.dir   = hwdata[tcc_pkg::CTRL_DIR];
          c_d.pa[0] = hwdata[tcc_pkg::CTRL_PA3];
        end
        default: ;
      endcase
    end

    // Set wins over a clear in the same cycle
    c_d.flag = (c_q.flag & ~flag_clr) | flag_set;

    for (int i = 0; i < NCH; i++) begin
      c_d.pend[i] = (evt[i] | c_q.pend[i]) & c_q.blk[i];
      if (evt[i]) begin
        k_d.held[i] = free_running_count;
      end
    end
    for (int i = 0; i < NUM_CAP; i++) begin
      if (go[i]) begin
        k_d.cap[i] = wval[i];
      end
    end

    // pin actions of channels two to five
    for (int j = 1; j < NUM_CMP; j++) begin
      if (act[j]) begin
        unique case (c_q.action[9 - 2 * j -: 2])
          tcc_pkg::ACT_OFF:    ;
          tcc_pkg::ACT_TOGGLE: c_d.pa[4 - j] = ~c_d.pa[4 - j];
          tcc_pkg::ACT_LOW:    c_d.pa[4 - j] = 1'b0;
          tcc_pkg::ACT_HIGH:   c_d.pa[4 - j] = 1'b1;
        endcase
      end
    end
    // channel one drives the masked pins last, so it wins
    if (act[0]) begin
      c_d.pa = (c_d.pa & ~c_q.pin_mask) | (c_q.pin_data & c_q.pin_mask);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // bit three driven as a compare output after reset
      c_q <= '{edge_ctl: tcc_pkg::BYTE_RESET, action: tcc_pkg::BYTE_RESET,
               irq_mask: tcc_pkg::BYTE_RESET, flag: tcc_pkg::BYTE_RESET,
               fsel: 1'b0, dir: 1'b0, pin_mask: tcc_pkg::PIN_RESET,
               pin_data: tcc_pkg::PIN_RESET, pa: tcc_pkg::PIN_RESET,
               blk: '0, pend: '0, wr_pend: 1'b0, wr_addr: '0, wr_lanes: '0, rdata: '0};
    end else begin
      c_q <= c_d;
    end
  end

  // latched on the edge, count stands still
  always_ff @(posedge hclk) begin
    k_q <= k_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pins and interrupt
  // Bit three drives when it is a compare output or set as output
  assign port_a_bit_three_oe = c_q.dir | ~c_q.fsel;
  assign port_a_out          = c_q.pa;
  assign timer_irq           = |(c_q.flag & c_q.irq_mask);

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_blocked_cap;
    evt[0] && c_q.blk[0] ##1 !evt[0] && !c_q.blk[0];
  endsequence

  AST_CAP_LOAD: assert property (
    (evt[0] && !c_q.blk[0]) |=> (k_q.cap[0] == $past(free_running_count)))
    else $error("capture did not latch the count");

  AST_CAP_BLOCK: assert property (
    (evt[0] && c_q.blk[0]) |=> (k_q.cap[0] == $past(k_q.cap[0])))
    else $error("capture written while blocked");

  AST_CAP_HELD: assert property (
    s_blocked_cap |=> (k_q.cap[0] == $past(free_running_count, 2)))
    else $error("held capture lost");

  AST_FLAG_MATCH: assert property (
    match[1] |=> c_q.flag[6] ##1 (c_q.flag[6] || $past(flag_clr[6])))
    else $error("match flag not set");

  AST_FLAG_KEEP: assert property (
    (c_q.flag[7] && !flag_clr[7]) |=> c_q.flag[7])
    else $error("flag lost without a one written");

  AST_TOGGLE: assert property (
    (match[1] && !match[0] && c_q.action[7:6] == tcc_pkg::ACT_TOGGLE)
      |=> (port_a_out[3] != $past(port_a_out[3])))
    else $error("toggle action missing");

  AST_OC1_PIN: assert property (
    (match[0] && c_q.pin_mask[4]) |=> (port_a_out[4] == $past(c_q.pin_data[4])))
    else $error("channel one data not driven");

endmodule : tcc_top

// ===== dv/tcc_far.sv
// Far-side model: outside counter, capture event sources, port A bit three wire.
// Assumes the bench drives run and ev just after rising edges.
`timescale 1ns/1ps
module tcc_far (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        run,
  input  wire logic [2:0]  ev,
  input  wire logic        pa3_ext,
  input  wire logic        pa3_oe,
  input  wire logic        pa3_drv,
  output logic      [15:0] count,
  output logic             count_step,
  output logic      [2:0]  capture_pin,
  output logic             pa3_in
);
  logic ph_q;
  //////////////////////////////////////////////////////////////////////////////
  // outside count source
  // Steps every second cycle so the count stands still between steps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count      <= 16'h0000;
      ph_q       <= 1'b0;
      count_step <= 1'b0;
    end else begin
      ph_q       <= run & ~ph_q;
      count_step <= run & ph_q;
      if (run && ph_q) begin
        count <= count + 16'h0001;
      end
    end
  end
  assign capture_pin = ev;
  assign pa3_in = pa3_oe ? pa3_drv : pa3_ext;
endmodule : tcc_far

// ===== dv/tcc_top_tb.sv
// Self-checking bench for the timer capture/compare block.
// Assumes a single AHB-Lite slave, hready tied to hreadyout.
`timescale 1ns/1ps
module tcc_top_tb;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} tcc_row_s;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, run;
  logic        pa3_ext, oe, irq, step, pa3_in, rdy;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ev, pins;
  logic [31:0] haddr, hwdata, hrdata, rd, rdat;
  logic [15:0] cnt, v1, v2;
  logic [4:0]  pa_out;
  int          failures, samples_checked;
  tcc_row_s rows[14] = '{
    '{1'b0, tcc_pkg::OFS_CMP1, 32'h0, 32'hFFFF}, '{1'b0, tcc_pkg::OFS_CMP4, 32'h0, 32'hFFFF},
    '{1'b0, tcc_pkg::OFS_SHARED, 32'h0, 32'hFFFF}, '{1'b0, tcc_pkg::OFS_EDGE, 32'h0, 32'h0},
    '{1'b0, tcc_pkg::OFS_CTRL, 32'h0, 32'h0}, '{1'b0, 8'h40, 32'h0, 32'h0},
    '{1'b1, tcc_pkg::OFS_CMP3, 32'hF234, 32'h0}, '{1'b0, tcc_pkg::OFS_CMP3, 32'h0, 32'hF234},
    '{1'b1, tcc_pkg::OFS_CTRL, 32'h1, 32'h0}, '{1'b1, tcc_pkg::OFS_SHARED, 32'hABC, 32'h0},
    '{1'b0, tcc_pkg::OFS_SHARED, 32'h0, 32'hFFFF}, '{1'b1, tcc_pkg::OFS_CTRL, 32'h0, 32'h0},
    '{1'b1, tcc_pkg::OFS_EDGE, 32'h1B, 32'h0}, '{1'b0, tcc_pkg::OFS_EDGE, 32'h0, 32'h1B}};

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  tcc_top u_tcc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .free_running_count(cnt), .count_step(step),
    .capture_pin(pins), .port_a_bit_three_in(pa3_in), .port_a_bit_three_oe(oe),
    .port_a_out(pa_out), .timer_irq(irq));
  tcc_far u_tcc_far (.hclk(hclk), .hresetn(hresetn), .run(run), .ev(ev), .pa3_ext(pa3_ext),
    .pa3_oe(oe), .pa3_drv(pa_out[0]), .count(cnt), .count_step(step), .capture_pin(pins),
    .pa3_in(pa3_in));

  //////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Mid-cycle look equals what the next rising edge samples
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      rdat = hrdata;
      @(posedge hclk);
      n++;
      if (n > 40) begin
        failures++;
        report_and_stop;
      end
    end while (rdy !== 1'b1);
  endtask : wt

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    r = rdat;
  endtask : bus

  task automatic wait_pa(input logic [4:0] e);
    int n;
    for (n = 0; n < 400 && pa_out !== e; n++) @(negedge hclk);
    chk("port_a_out", {27'h0, e}, {27'h0, pa_out});
  endtask : wait_pa

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; htrans = 0; haddr = 0; hwrite = 0; hsize = 0; hwdata = 0;
    run = 1; ev = 0; pa3_ext = 0; failures = 0; samples_checked = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d, rd);
      if (!rows[i].w) chk("register", rows[i].e, rd);
    end
    // Count frozen so each edge has one known count
    @(posedge hclk) run <= 1'b0;
    repeat (4) @(posedge hclk);
    v1 = cnt;
    ev <= 3'h7;
    repeat (4) @(posedge hclk) run <= 1'b1;
    repeat (9) @(posedge hclk) run <= 1'b0;
    repeat (4) @(posedge hclk);
    v2 = cnt;
    ev <= 3'h0;
    repeat (4) @(posedge hclk) run <= 1'b1;
    bus(1'b0, tcc_pkg::OFS_CAP1, 32'h0, rd); chk("cap1", {16'h0, v1}, rd);
    bus(1'b0, tcc_pkg::OFS_CAP2, 32'h0, rd); chk("cap2", {16'h0, v2}, rd);
    bus(1'b0, tcc_pkg::OFS_CAP3, 32'h0, rd); chk("cap3", {16'h0, v2}, rd);
    bus(1'b0, tcc_pkg::OFS_FLAG, 32'h0, rd); chk("flag", 32'h07, rd);
    bus(1'b1, tcc_pkg::OFS_FLAG, 32'h07, rd);
    bus(1'b0, tcc_pkg::OFS_FLAG, 32'h0, rd); chk("flag", 32'h0, rd);
    bus(1'b1, tcc_pkg::OFS_ACTION, 32'h40, rd);
    bus(1'b1, tcc_pkg::OFS_MASK, 32'h40, rd);
    v1 = cnt + 16'h0030;
    bus(1'b1, tcc_pkg::OFS_CMP2, {16'h0, v1}, rd);
    wait_pa(5'h08);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, tcc_pkg::OFS_FLAG, 32'h80, rd);
    bus(1'b0, tcc_pkg::OFS_FLAG, 32'h0, rd); chk("flag", 32'h40, rd);
    bus(1'b1, tcc_pkg::OFS_FLAG, 32'h40, rd);
    // The clear lands on the edge that ends the write; look once it has settled
    @(negedge hclk);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'b1, tcc_pkg::OFS_PINMASK, 32'hF8, rd);
    bus(1'b1, tcc_pkg::OFS_PINDATA, 32'hA8, rd);
    v1 = cnt + 16'h0030;
    bus(1'b1, tcc_pkg::OFS_CMP1, {16'h0, v1}, rd);
    wait_pa(5'h15);
    // Count frozen: an edge in the cycle blocked by a high-byte read, then a software edge on bit three
    @(posedge hclk) run <= 1'b0;
    repeat (4) @(posedge hclk);
    v2 = cnt;
    fork
      bus(1'b0, tcc_pkg::OFS_CAP1, 32'h0, rd);
      begin
        repeat (2) @(posedge hclk);
        ev <= 3'h1;
      end
    join
    bus(1'b0, tcc_pkg::OFS_CAP1, 32'h0, rd); chk("cap1", {16'h0, v2}, rd);
    bus(1'b1, tcc_pkg::OFS_EDGE, 32'h5B, rd);
    bus(1'b1, tcc_pkg::OFS_CTRL, 32'h3, rd);
    bus(1'b1, tcc_pkg::OFS_CTRL, 32'h7, rd);
    bus(1'b0, tcc_pkg::OFS_SHARED, 32'h0, rd); chk("shared", {16'h0, v2}, rd);
    // Mid-run reset: the three capture registers survive, the rest, shared register included, returns to reset values
    @(posedge hclk) hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, tcc_pkg::OFS_CAP1, 32'h1234, rd);
    bus(1'b0, tcc_pkg::OFS_CAP1, 32'h0, rd); chk("cap1", {16'h0, v2}, rd);
    bus(1'b0, tcc_pkg::OFS_SHARED, 32'h0, rd); chk("shared", 32'hFFFF, rd);
    bus(1'b0, tcc_pkg::OFS_EDGE, 32'h0, rd); chk("edge", 32'h0, rd);
    bus(1'b0, tcc_pkg::OFS_CTRL, 32'h0, rd); chk("ctrl", 32'h0, rd);
    chk("oe", 32'h1, {31'h0, oe});
    report_and_stop;
  end

  initial begin
    #1000000;
    failures++;
    report_and_stop;
  end
endmodule : tcc_top_tb
